/* File: design/dss_stop_seq.sv */
// drive stop sequencer: stop ramps, limit timers, contactor hold and current decay
`timescale 1ns/10ps
module dss_stop_seq #(
   parameter int TICK_CYCLES = dss_pkg::TICK_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control terminals, asynchronous
   input wire logic run_terminal,
   input wire logic fast_stop_terminal,
   input wire logic enable_terminal,
   input wire logic freewheel_terminal,
   // loop values, 0.01 % units
   input wire logic signed [15:0] speed_setpoint,
   input wire logic signed [15:0] speed_feedback,
   input wire logic [15:0] current_limit_in,
   // settings, times in 0.1 s
   input wire logic [15:0] normal_ramp_time,
   input wire logic [15:0] normal_abort_time,
   input wire logic [15:0] contactor_delay_time,
   input wire logic [15:0] fast_ramp_time,
   input wire logic [15:0] fast_abort_time,
   // settings, 0.01 % and 0.01 %/s
   input wire logic [15:0] fast_current_cap,
   input wire logic [15:0] current_ramp_down_rate,
   input wire logic [15:0] stop_zero_speed,
   // outputs
   output logic signed [15:0] speed_demand,
   output logic [15:0] current_limit,
   output logic contactor_pilot,
   output logic drive_enable,
   output logic loop_reset,
   output logic fast_cap_active
);
   import dss_pkg::*;

   dss_reg_s s;
   dss_reg_s n;
   logic tick;
   logic coast;
   logic en;
   logic fast;
   logic run;
   logic fb_at_zero;
   logic early_off;
   logic [19:0] period;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////////////
   // tick and decoded inputs

   dss_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .clk(clk),
      .rst(rst),
      .tick(tick)
   );

   assign coast = !s.sync2[SYN_COAST_N];
   assign en = s.sync2[SYN_EN];
   assign fast = !s.sync2[SYN_FAST_N];
   assign run = s.sync2[SYN_RUN];
   assign fb_at_zero = dss_abs(speed_feedback) <= stop_zero_speed;
   assign early_off = (stop_zero_speed > EARLY_OFF_LEVEL) && (current_ramp_down_rate != 16'h0000);
   assign period = dss_ds_to_ms((s.st == ST_FAST) ? fast_ramp_time : normal_ramp_time);

   ////////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb
   begin
      n = s;
      n.sync1 = {run_terminal, fast_stop_terminal, enable_terminal, freewheel_terminal};
      n.sync2 = s.sync1;
      if (tick)
      begin
         n.timer = s.timer + 20'h00001;
      end
      // stop ramp toward zero, one count per cycle while the accumulator allows
      if (s.st == ST_NSTOP || s.st == ST_FAST)
      begin
         if (period == 20'h00000)
         begin
            n.demand = '0;
         end
         else if (tick)
         begin
            n.acc = s.acc + 20'(FULL_SCALE);
         end
         else if (s.acc >= period)
         begin
            n.acc = s.acc - period;
            if (s.demand > 16'sh0000)
            begin
               n.demand = s.demand - 16'sh0001;
            end
            else if (s.demand < 16'sh0000)
            begin
               n.demand = s.demand + 16'sh0001;
            end
         end
      end
      if (!run)
      begin
         n.run_armed = 1'b1;
      end
      else if (coast || fast)
      begin
         n.run_armed = 1'b0;
      end
      case (s.st)
         ST_IDLE:
         begin
            n.demand = '0;
            n.acc = '0;
            if (run && s.run_armed && !coast && !fast)
            begin
               n.st = ST_RUN;
               n.run_armed = 1'b0;
            end
         end
         ST_RUN:
         begin
            n.demand = speed_setpoint;
            n.acc = '0;
            n.timer = '0;
            if (fast)
            begin
               n.st = ST_FAST;
            end
            else if (!run)
            begin
               n.st = ST_NSTOP;
            end
         end
         ST_NSTOP:
         begin
            if (fast)
            begin
               n.st = ST_FAST;
               n.timer = '0;
            end
            else if (run)
            begin
               n.st = ST_RUN;
            end
            else if (fb_at_zero)
            begin
               n.st = ST_HOLD;
               n.timer = '0;
               n.demand = '0;
            end
            else if (s.timer >= dss_ds_to_ms(normal_abort_time))
            begin
               n.st = ST_IDLE;
            end
         end
         ST_HOLD:
         begin
            n.demand = '0;
            if (fast)
            begin
               n.st = ST_FAST;
               n.timer = '0;
            end
            else if (!en)
            begin
               n.st = ST_IDLE;
            end
            else if (run)
            begin
               n.st = ST_RUN;
            end
            else if (s.timer >= dss_ds_to_ms(contactor_delay_time))
            begin
               n.st = ST_IDLE;
            end
         end
         ST_FAST:
         begin
            if (fb_at_zero || s.timer >= dss_ds_to_ms(fast_abort_time))
            begin
               n.st = ST_IDLE;
            end
         end
         default:
         begin
            n.st = ST_IDLE;
         end
      endcase
      if (coast)
      begin
         n.st = ST_IDLE;
      end
      // outputs
      n.contactor = !coast && (n.st != ST_IDLE);
      n.drive_en = !coast && en && (n.st == ST_RUN || n.st == ST_NSTOP || n.st == ST_FAST
                   || (n.st == ST_HOLD && !early_off));
      n.loop_reset = !en;
      n.fast_cap = (n.st == ST_FAST) && n.drive_en;
      // current limit, decays at current_ramp_down_rate while the loop is disabled, cleared at once when that rate is zero
      if (n.drive_en)
      begin
         n.cur = n.fast_cap ? fast_current_cap : current_limit_in;
         n.cur_acc = '0;
      end
      else if (current_ramp_down_rate == 16'h0000)
      begin
         n.cur = '0;
         n.cur_acc = '0;
      end
      else if (tick)
      begin
         n.cur_acc = s.cur_acc + current_ramp_down_rate;
      end
      else if (s.cur_acc >= DECAY_DIV)
      begin
         n.cur_acc = s.cur_acc - DECAY_DIV;
         if (s.cur != 16'h0000)
         begin
            n.cur = s.cur - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= DSS_RESET;
      end
      else
      begin
         s <= n;
      end
   end

   assign speed_demand = s.demand;
   assign current_limit = s.cur;
   assign contactor_pilot = s.contactor;
   assign drive_enable = s.drive_en;
   assign loop_reset = s.loop_reset;
   assign fast_cap_active = s.fast_cap;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   sequence fast_reaches_zero;
      s.st == ST_FAST && fb_at_zero;
   endsequence

   sequence hold_expired;
      s.st == ST_HOLD && en && !fast && !run && s.timer >= dss_ds_to_ms(contactor_delay_time);
   endsequence

   a_coast_opens: assert property (coast |=> !contactor_pilot && !drive_enable)
      else $error("coast stop left contactor or drive on");
   a_enable_resets: assert property (!en |=> loop_reset && !drive_enable)
      else $error("enable removal did not reset loops");
   a_fast_cap_used: assert property (s.st == ST_FAST && s.drive_en |-> current_limit == $past(fast_current_cap))
      else $error("fast stop current cap not applied");
   a_hold_zero: assert property (s.st == ST_HOLD |-> speed_demand == 16'sh0000)
      else $error("demand not zero during contactor hold");
   a_fast_zero_off: assert property (fast_reaches_zero |=> s.st == ST_IDLE && !contactor_pilot && !drive_enable)
      else $error("fast stop at zero speed did not open contactor");
   a_fast_abort: assert property (s.st == ST_FAST && s.timer >= dss_ds_to_ms(fast_abort_time)
      |=> s.st == ST_IDLE && !drive_enable && !contactor_pilot)
      else $error("fast stop abort time not honoured");
   a_normal_abort: assert property (s.st == ST_NSTOP && !fast && !run && !fb_at_zero
      && s.timer >= dss_ds_to_ms(normal_abort_time) |=> s.st == ST_IDLE)
      else $error("normal stop abort time not honoured");
   a_hold_expires: assert property (hold_expired |=> s.st == ST_IDLE && !contactor_pilot)
      else $error("contactor hold did not end");
   a_run_blocked: assert property (s.st == ST_IDLE && (coast || fast)
      |=> s.st == ST_IDLE && !drive_enable && !contactor_pilot)
      else $error("run accepted while a stop was active");
   a_run_disarm: assert property (run && (coast || fast) |=> !s.run_armed)
      else $error("run stayed armed while a stop was active");
   a_ramp_down: assert property (s.st == ST_NSTOP ##1 s.st == ST_NSTOP |-> dss_abs(s.demand) <= $past(dss_abs(s.demand)))
      else $error("normal stop demand rose");
   a_hold_cancel: assert property (s.st == ST_HOLD && !en && !fast && !coast |=> s.st == ST_IDLE)
      else $error("enable low did not cancel hold");
   a_early_off: assert property (s.st == ST_HOLD && $past(early_off) |-> !drive_enable)
      else $error("drive enabled during hold with early disable");
   a_decay_fall: assert property (!s.drive_en ##1 !s.drive_en |-> current_limit <= $past(current_limit))
      else $error("current limit rose while loop disabled");
endmodule

/* File: pkg/dss_pkg.sv */
// package: constants, state types and helpers of the drive stop sequencer
// Functional notes
// - normal stop ramps demand to zero; full scale takes the normal ramp time
// - fast stop ramps demand to zero; full scale takes the fast ramp time
// - fast stop timing starts when the fast stop terminal goes low
// - fast stop: speed at zero threshold opens contactor and disables drive
// - fast stop lasting beyond its abort time opens contactor and disables drive
// - during fast stop the current limit output carries the fast current cap; here only while enable is present, else it decays or clears at a zero rate
// - normal stop abort timer starts at run low; expiry makes drive coast
// - at zero threshold contactor stays in for the delay, demand held zero
// - with the current loop disabled the limit decays at the programmed rate; here a zero rate clears the limit to zero at once
// - zero speed threshold is the level that starts the contactor delay
// - coast stop disables the drive and opens the contactor pilot
// - enable removal suspends the loops and resets them
// - run applied while coast or fast stop is active keeps drive stopped
// - threshold above 0.25% with nonzero decay disables during the delay
// - enable low cancels a running contactor delay hold
package dss_pkg;
   // timing
   localparam int CLK_MHZ = 200;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = CLK_MHZ * TICK_TIME_US;
   localparam int TICKS_PER_S = 1000000 / TICK_TIME_US;
   localparam int TICKS_PER_DS = TICKS_PER_S / 10;
   localparam logic [19:0] MS_PER_DS = 20'(TICKS_PER_DS);
   localparam logic [15:0] DECAY_DIV = 16'(TICKS_PER_S);
   // levels in 0.01 % units
   localparam logic [15:0] FULL_SCALE = 16'h2710;
   localparam logic [15:0] EARLY_OFF_LEVEL = 16'h0019;
   // synchroniser bit positions
   localparam int SYN_COAST_N = 0;
   localparam int SYN_EN = 1;
   localparam int SYN_FAST_N = 2;
   localparam int SYN_RUN = 3;
   // synchroniser reset levels: run low, fast and coast released, enable present
   localparam logic [3:0] SYNC_IDLE = 4'h7;

   typedef enum logic [2:0]
   {
      ST_IDLE = 3'h0,
      ST_RUN = 3'h1,
      ST_NSTOP = 3'h3,
      ST_HOLD = 3'h2,
      ST_FAST = 3'h6
   } dss_state_e;

   typedef struct packed {
      logic [3:0] sync1;
      logic [3:0] sync2;
      dss_state_e st;
      logic run_armed;
      logic [19:0] timer;
      logic [19:0] acc;
      logic signed [15:0] demand;
      logic [15:0] cur_acc;
      logic [15:0] cur;
      logic contactor;
      logic drive_en;
      logic loop_reset;
      logic fast_cap;
   } dss_reg_s;

   // synchronisers start at the idle pin levels so no false stop or loop reset follows reset
   localparam dss_reg_s DSS_RESET = '{st: ST_IDLE, sync1: SYNC_IDLE, sync2: SYNC_IDLE, default: '0};

   function automatic logic [15:0] dss_abs(input logic signed [15:0] v);
      dss_abs = v[15] ? 16'(-v) : 16'(v);
   endfunction

   function automatic logic [19:0] dss_ds_to_ms(input logic [15:0] ds);
      dss_ds_to_ms = 20'({4'h0, ds} * MS_PER_DS);
   endfunction
endpackage

/* File: design/dss_tick_div.sv */
// control tick divider: one-cycle pulse every TICK_CYCLES clocks
`timescale 1ns/10ps
module dss_tick_div #(
   parameter int TICK_CYCLES = dss_pkg::TICK_CYCLES
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // tick out
   output logic tick
);
   import dss_pkg::*;

   typedef struct packed {
      logic [31:0] cnt;
      logic tick;
   } dss_div_s;

   dss_div_s s;
   dss_div_s next_s;

   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.cnt >= 32'(TICK_CYCLES - 1))
      begin
         next_s.cnt = '0;
         next_s.tick = 1'b1;
      end
      else
      begin
         next_s.cnt = s.cnt + 32'h00000001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign tick = s.tick;
endmodule

/* File: tb/dss_plant.sv */
// plant model: speed loop and armature as seen from the stop sequencer
`timescale 1ns/10ps
module dss_plant
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // from the sequencer
   input wire logic signed [15:0] speed_demand,
   input wire logic drive_enable,
   input wire logic contactor_pilot,
   // response: 0 prompt, 1 slow, 2 stalled shaft
   input wire logic [1:0] plant_mode,
   // to the sequencer
   output logic signed [15:0] speed_feedback
);
   logic signed [15:0] target;
   // a disabled drive or open contactor lets the shaft run down
   always_comb
   begin
      target = (drive_enable && contactor_pilot) ? speed_demand : 16'sh0000;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         speed_feedback <= 16'sh0000;
      else if (plant_mode == 2'h0)
         speed_feedback <= target;
      else if (plant_mode == 2'h1 && speed_feedback > target + 16'sh0008)
         speed_feedback <= speed_feedback - 16'sh0008;
      else if (plant_mode == 2'h1 && speed_feedback < target - 16'sh0008)
         speed_feedback <= speed_feedback + 16'sh0008;
      else if (plant_mode == 2'h1)
         speed_feedback <= target;
   end
endmodule

/* File: tb/dss_stop_seq_test.sv */
// testbench: directed stop scenarios for the stop sequencer
`timescale 1ns/10ps
module dss_stop_seq_test;
   logic clk = 1'b0;
   logic rst, run_terminal, fast_stop_terminal, enable_terminal, freewheel_terminal;
   logic [1:0] plant_mode;
   logic signed [15:0] speed_setpoint, speed_feedback, speed_demand;
   logic [15:0] current_limit_in, normal_ramp_time, normal_abort_time, contactor_delay_time;
   logic [15:0] fast_ramp_time, fast_abort_time, fast_current_cap, current_ramp_down_rate;
   logic [15:0] stop_zero_speed, current_limit;
   logic contactor_pilot, drive_enable, loop_reset, fast_cap_active;
   int mismatches = 0;
   int n_tests = 0;
   always #2.5 clk = ~clk;
   dss_stop_seq #(.TICK_CYCLES(20)) dut (.clk, .rst, .run_terminal, .fast_stop_terminal,
      .enable_terminal, .freewheel_terminal, .speed_setpoint, .speed_feedback, .current_limit_in,
      .normal_ramp_time, .normal_abort_time, .contactor_delay_time, .fast_ramp_time,
      .fast_abort_time, .fast_current_cap, .current_ramp_down_rate, .stop_zero_speed,
      .speed_demand, .current_limit, .contactor_pilot, .drive_enable, .loop_reset, .fast_cap_active);
   dss_plant plant (.clk, .rst, .speed_demand, .drive_enable, .contactor_pilot, .plant_mode,
      .speed_feedback);
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rst_dut;
      rst = 1'b1;
      run_terminal = 1'b0;
      fast_stop_terminal = 1'b1;
      enable_terminal = 1'b1;
      freewheel_terminal = 1'b1;
      plant_mode = 2'h0;
      speed_setpoint = 16'sh03E8;
      current_limit_in = 16'h1388;
      normal_ramp_time = 16'h000A;
      normal_abort_time = 16'h0064;
      contactor_delay_time = 16'h0001;
      fast_ramp_time = 16'h000A;
      fast_abort_time = 16'h0064;
      fast_current_cap = 16'h3A98;
      current_ramp_down_rate = 16'h0000;
      stop_zero_speed = 16'h000A;
      cyc(6);
      rst = 1'b0;
      cyc(2);
   endtask
   task automatic go_run;
      rst_dut;
      run_terminal = 1'b1;
      cyc(6);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_start;
      rst_dut;
      chk("idle pilot", 16'h0000, {15'h0, contactor_pilot});
      chk("idle loop reset", 16'h0000, {15'h0, loop_reset});
      run_terminal = 1'b1;
      cyc(6);
      chk("run pilot", 16'h0003, {14'h0, contactor_pilot, drive_enable});
      chk("run demand", 16'h03E8, speed_demand);
      chk("run limit", 16'h1388, current_limit);
      rst = 1'b1;
      cyc(2);
      chk("reset pilot", 16'h0000, {14'h0, contactor_pilot, drive_enable});
      $display("start done");
   endtask
   task automatic t_fast;
      go_run;
      fast_stop_terminal = 1'b0;
      cyc(100);
      chk("fast cap flag", 16'h0001, {15'h0, fast_cap_active});
      chk("fast cap", 16'h3A98, current_limit);
      chk("fast ramp", 16'h0001, {15'h0, speed_demand >= 16'sh03B6 && speed_demand <= 16'sh03CA});
      cyc(1700);
      chk("fast running", 16'h0003, {14'h0, contactor_pilot, drive_enable});
      cyc(400);
      chk("fast end", 16'h0000, {13'h0, contactor_pilot, drive_enable, fast_cap_active});
      $display("fast stop done");
   endtask
   task automatic t_fast_abort;
      go_run;
      plant_mode = 2'h2;
      fast_abort_time = 16'h0001;
      fast_stop_terminal = 1'b0;
      cyc(1900);
      chk("abort early", 16'h0001, {15'h0, contactor_pilot});
      cyc(300);
      chk("abort late", 16'h0000, {14'h0, contactor_pilot, drive_enable});
      $display("fast abort done");
   endtask
   task automatic t_normal;
      go_run;
      run_terminal = 1'b0;
      cyc(100);
      chk("ramping", 16'h0001, {15'h0, speed_demand >= 16'sh03B6 && speed_demand <= 16'sh03CA});
      cyc(2000);
      chk("hold", 16'h0003, {14'h0, contactor_pilot, drive_enable});
      chk("hold demand", 16'h0000, speed_demand);
      cyc(1700);
      chk("hold on", 16'h0001, {15'h0, contactor_pilot});
      cyc(400);
      chk("hold end", 16'h0000, {14'h0, contactor_pilot, drive_enable});
      $display("normal stop done");
   endtask
   task automatic t_hold_enable;
      go_run;
      stop_zero_speed = 16'h00C8;
      current_ramp_down_rate = 16'h2710;
      run_terminal = 1'b0;
      cyc(1800);
      chk("early off", 16'h0002, {14'h0, contactor_pilot, drive_enable});
      chk("decaying", 16'h0001, {15'h0, current_limit >= 16'h1310 && current_limit <= 16'h1338});
      enable_terminal = 1'b0;
      cyc(6);
      chk("hold cut", 16'h0000, {15'h0, contactor_pilot});
      chk("loop reset", 16'h0001, {15'h0, loop_reset});
      $display("hold and enable done");
   endtask
   task automatic t_normal_abort;
      go_run;
      plant_mode = 2'h2;
      normal_abort_time = 16'h0000;
      run_terminal = 1'b0;
      cyc(8);
      chk("coast out", 16'h0000, {14'h0, contactor_pilot, drive_enable});
      $display("normal abort done");
   endtask
   task automatic t_coast;
      go_run;
      plant_mode = 2'h2;
      fast_stop_terminal = 1'b0;
      cyc(50);
      chk("coast fast", 16'h0001, {15'h0, fast_cap_active});
      freewheel_terminal = 1'b0;
      cyc(8);
      chk("coast", 16'h0000, {14'h0, contactor_pilot, drive_enable});
      chk("coast limit", 16'h0000, current_limit);
      $display("coast done");
   endtask
   task automatic t_refuse;
      rst_dut;
      fast_stop_terminal = 1'b0;
      run_terminal = 1'b1;
      cyc(10);
      chk("refused", 16'h0000, {14'h0, contactor_pilot, drive_enable});
      fast_stop_terminal = 1'b1;
      cyc(10);
      chk("disarmed", 16'h0000, {15'h0, contactor_pilot});
      run_terminal = 1'b0;
      cyc(5);
      run_terminal = 1'b1;
      cyc(6);
      chk("rearmed", 16'h0001, {15'h0, contactor_pilot});
      $display("refuse done");
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      t_start;
      t_fast;
      t_fast_abort;
      t_normal;
      t_hold_enable;
      t_normal_abort;
      t_coast;
      t_refuse;
      end_sim;
   end
   // tests need about 11000 cycles (55 us); allow about seven times that
   initial
   begin
      #400us;
      mismatches++;
      end_sim;
   end
endmodule
